/* pclt_defines.vh */
// pclt_defines.vh: offsets, field positions, reset values and codes for the
// pixel colour convert and table stage; definitions only
`ifndef PCLT_DEFINES_VH
`define PCLT_DEFINES_VH
// register offsets
`define PCLT_REG_CTRL 4'h0
`define PCLT_REG_INFMT 4'h1
`define PCLT_REG_OUTFMT 4'h2
`define PCLT_REG_INDEX 4'h3
`define PCLT_REG_RED 4'h4
`define PCLT_REG_GREEN 4'h5
`define PCLT_REG_BLUE 4'h6
`define PCLT_REG_STATUS 4'h7
`define PCLT_REG_LOAD 4'h8
`define PCLT_REG_PROC 4'h9
// ctrl fields
`define PCLT_CTRL_ENABLE 0
`define PCLT_CTRL_SOURCE 1
// load register fields
`define PCLT_LOAD_START 0
`define PCLT_LOAD_VALID 1
// status fields
`define PCLT_STAT_BUSY 0
`define PCLT_STAT_ERROR 1
`define PCLT_STAT_PATH 2
// reset values
`define PCLT_RST_ENABLE 1'h0
`define PCLT_RST_SOURCE 1'h0
`define PCLT_RST_FMT 2'h0
// source select codes
`define PCLT_SRC_PROC 1'h0
`define PCLT_SRC_FILE 1'h1
// pixel layout codes
`define PCLT_FMT_MONO 2'h0
`define PCLT_FMT_RGB 2'h1
`define PCLT_FMT_BAYER 2'h2
`define PCLT_FMT_YCC 2'h3
// pipeline latency in cycles
`define PCLT_LATENCY 3
`endif

/* pclt_skid.v */
// pclt_skid.v: two-entry ready/valid buffer for the output word
// assumes one clock, synchronous active-high reset, clock enable freezes it
`timescale 1ns/1ps
`default_nettype none
module pclt_skid #(
   parameter W = 51
) (
   // clock
   input wire sys_clk,
   input wire sys_rst,
   input wire clk_en,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem_q [0:1];
   reg wr_q;
   reg rd_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (clk_en) begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule // pclt_skid
`default_nettype wire

/* pclt_core.v */
// pclt_core.v: pixel format converter followed by per-component remap tables
// assumes pixels arrive after demosaic, synchronous to sys_clk; register port
// is a plain strobe bus with read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "pclt_defines.vh"
// Behaviour
// - only listed format pairs are converted
// - unsupported pairings pass pixels unchanged
// - converter sits directly before table stage
// - separate full table per red, green, blue
// - table remap is last step before output
// - index is top 14 of 16 bits
// - entries are 16 bit and replace pixel
// - remap precedes downstream output formatting
// - enable defaults off; off bypasses remap
// - source select defaults to processor
// - single entry writes always accepted
// - processor or file load rewrites whole table
// - 16384 entries, index selector, reset zero
// - valid file loads; invalid flags error
// - one entry per four input values, substituted
// - processor results clamped to 0..65535
module pclt_core #(
   parameter PW = 16,
   parameter IW = 14
) (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   input wire clk_en,
   // register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // table fill from processor or file parser: one entry per cycle
   input wire fill_valid,
   input wire [IW-1:0] fill_index,
   input wire [PW-1:0] fill_red,
   input wire [PW-1:0] fill_green,
   input wire [PW-1:0] fill_blue,
   input wire signed [PW+1:0] fill_raw_red,
   input wire signed [PW+1:0] fill_raw_green,
   input wire signed [PW+1:0] fill_raw_blue,
   input wire fill_use_raw,
   input wire fill_last,
   // requests to the fill sources
   output reg proc_regen,
   output reg file_load,
   // pixel input from demosaic
   input wire in_valid,
   output wire in_ready,
   input wire [PW-1:0] in_red,
   input wire [PW-1:0] in_green,
   input wire [PW-1:0] in_blue,
   input wire in_sof,
   input wire in_eol,
   // pixel output to host transfer
   output wire out_valid,
   input wire out_ready,
   output wire [PW-1:0] out_red,
   output wire [PW-1:0] out_green,
   output wire [PW-1:0] out_blue,
   output wire out_sof,
   output wire out_eol
);
   localparam DEPTH = 1 << IW;
   localparam [PW-1:0] MAXV = {PW{1'b1}};
   localparam OW = 3 * PW + 2;
   localparam [1:0] LD_IDLE = 2'h0;
   localparam [1:0] LD_WAIT = 2'h1;

   reg table_enable_q;
   reg table_source_select_q;
   reg [1:0] infmt_q;
   reg [1:0] outfmt_q;
   reg [IW-1:0] table_entry_index_q;
   reg load_err_q;
   reg [1:0] ld_state_q;
   reg [PW-1:0] tab_r [0:DEPTH-1];
   reg [PW-1:0] tab_g [0:DEPTH-1];
   reg [PW-1:0] tab_b [0:DEPTH-1];
   reg [PW-1:0] rd_word_q;
   reg rd_pend_q;
   reg [3:0] rd_sel_q;

   // pipeline state: stage 1 converts, stage 2 looks up
   reg s1_v_q;
   reg [PW-1:0] s1_r_q;
   reg [PW-1:0] s1_g_q;
   reg [PW-1:0] s1_b_q;
   reg [1:0] s1_m_q;
   reg s2_v_q;
   reg [PW-1:0] s2_r_q;
   reg [PW-1:0] s2_g_q;
   reg [PW-1:0] s2_b_q;
   reg [1:0] s2_m_q;
   reg s2_lut_q;
   wire adv;
   wire buf_ready;

   // format conversion
   reg [PW-1:0] cv_r;
   reg [PW-1:0] cv_g;
   reg [PW-1:0] cv_b;
   reg [PW+1:0] luma;
   reg conv_path;

   // bus decode
   wire wr_ctrl = reg_wr & (reg_addr == `PCLT_REG_CTRL);
   wire wr_entry = reg_wr & ((reg_addr == `PCLT_REG_RED) | (reg_addr == `PCLT_REG_GREEN) |
      (reg_addr == `PCLT_REG_BLUE));
   wire wr_load = reg_wr & (reg_addr == `PCLT_REG_LOAD);
   wire wr_proc = reg_wr & (reg_addr == `PCLT_REG_PROC);
   wire busy = (ld_state_q != LD_IDLE);

   // clamp a signed processor result to the output range
   function [PW-1:0] clamp;
      input signed [PW+1:0] v;
      begin
         if (v < 0) begin
            clamp = {PW{1'b0}};
         end else if (v > $signed({2'b00, MAXV})) begin
            clamp = MAXV;
         end else begin
            clamp = v[PW-1:0];
         end
      end
   endfunction

   always @* begin
      cv_r = in_red;
      cv_g = in_green;
      cv_b = in_blue;
      conv_path = 1'b0;
      luma = ({2'b00, in_red} + {1'b0, in_green, 1'b0} + {2'b00, in_blue}) >> 2;
      case (outfmt_q)
         `PCLT_FMT_MONO: begin
            if (infmt_q == `PCLT_FMT_RGB || infmt_q == `PCLT_FMT_BAYER) begin
               cv_r = luma[PW-1:0];
               cv_g = luma[PW-1:0];
               cv_b = luma[PW-1:0];
               conv_path = 1'b1;
            end else if (infmt_q == `PCLT_FMT_MONO) begin
               conv_path = 1'b1;
            end
         end
         `PCLT_FMT_RGB: begin
            if (infmt_q == `PCLT_FMT_MONO) begin
               cv_g = in_red;
               cv_b = in_red;
               conv_path = 1'b1;
            end else if (infmt_q != `PCLT_FMT_YCC) begin
               conv_path = 1'b1;
            end
         end
         `PCLT_FMT_BAYER: begin
            conv_path = (infmt_q == `PCLT_FMT_BAYER);
         end
         `PCLT_FMT_YCC: begin
            conv_path = (infmt_q == `PCLT_FMT_YCC);
         end
         default: begin
            conv_path = 1'b0;
         end
      endcase
      if (!conv_path) begin
         cv_r = in_red;
         cv_g = in_green;
         cv_b = in_blue;
      end
   end

   // whole pipeline advances together while the buffer has room
   assign adv = clk_en & (buf_ready | ~s2_v_q);
   assign in_ready = adv;

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_v_q <= 1'b0;
         s2_v_q <= 1'b0;
         s1_m_q <= 2'h0;
         s2_m_q <= 2'h0;
         s2_lut_q <= 1'b0;
      end else if (adv) begin
         s1_v_q <= in_valid;
         s1_m_q <= {in_sof, in_eol};
         s1_r_q <= cv_r;
         s1_g_q <= cv_g;
         s1_b_q <= cv_b;
         s2_v_q <= s1_v_q;
         s2_m_q <= s1_m_q;
         s2_lut_q <= table_enable_q;
         s2_r_q <= s1_r_q;
         s2_g_q <= s1_g_q;
         s2_b_q <= s1_b_q;
      end
   end

   // lookup result is read from s2 values; bypass when disabled
   wire [PW-1:0] lk_r = s2_lut_q ? tab_r[s2_r_q[PW-1 -: IW]] : s2_r_q;
   wire [PW-1:0] lk_g = s2_lut_q ? tab_g[s2_g_q[PW-1 -: IW]] : s2_g_q;
   wire [PW-1:0] lk_b = s2_lut_q ? tab_b[s2_b_q[PW-1 -: IW]] : s2_b_q;

   // last stage before host path: buffer holds final words
   pclt_skid #(
      .W(OW)
   ) u_skid (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(s2_v_q & adv),
      .in_ready(buf_ready),
      .in_data({lk_r, lk_g, lk_b, s2_m_q}),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data({out_red, out_green, out_blue, out_sof, out_eol})
   );

   // table writes: fill source and single entries, last writer wins
   always @(posedge sys_clk) begin
      if (clk_en) begin
         if (fill_valid && busy) begin
            tab_r[fill_index] <= fill_use_raw ? clamp(fill_raw_red) : fill_red;
            tab_g[fill_index] <= fill_use_raw ? clamp(fill_raw_green) : fill_green;
            tab_b[fill_index] <= fill_use_raw ? clamp(fill_raw_blue) : fill_blue;
         end
         if (wr_entry) begin
            if (reg_addr == `PCLT_REG_RED) begin
               tab_r[table_entry_index_q] <= reg_wdata[PW-1:0];
            end
            if (reg_addr == `PCLT_REG_GREEN) begin
               tab_g[table_entry_index_q] <= reg_wdata[PW-1:0];
            end
            if (reg_addr == `PCLT_REG_BLUE) begin
               tab_b[table_entry_index_q] <= reg_wdata[PW-1:0];
            end
         end
      end
   end

   // control registers and load sequencer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         table_enable_q <= `PCLT_RST_ENABLE;
         table_source_select_q <= `PCLT_RST_SOURCE;
         infmt_q <= `PCLT_RST_FMT;
         outfmt_q <= `PCLT_RST_FMT;
         table_entry_index_q <= {IW{1'b0}};
         load_err_q <= 1'b0;
         ld_state_q <= LD_IDLE;
         proc_regen <= 1'b0;
         file_load <= 1'b0;
      end else if (clk_en) begin
         proc_regen <= 1'b0;
         file_load <= 1'b0;
         if (wr_ctrl) begin
            table_enable_q <= reg_wdata[`PCLT_CTRL_ENABLE];
            table_source_select_q <= reg_wdata[`PCLT_CTRL_SOURCE];
         end
         if (reg_wr && reg_addr == `PCLT_REG_INFMT) begin
            infmt_q <= reg_wdata[1:0];
         end
         if (reg_wr && reg_addr == `PCLT_REG_OUTFMT) begin
            outfmt_q <= reg_wdata[1:0];
         end
         if (reg_wr && reg_addr == `PCLT_REG_INDEX) begin
            table_entry_index_q <= reg_wdata[IW-1:0];
         end
         case (ld_state_q)
            LD_IDLE: begin
               if (wr_load && reg_wdata[`PCLT_LOAD_START]) begin
                  // file ignored unless file source chosen
                  if (table_source_select_q == `PCLT_SRC_FILE) begin
                     if (reg_wdata[`PCLT_LOAD_VALID]) begin
                        load_err_q <= 1'b0;
                        file_load <= 1'b1;
                        ld_state_q <= LD_WAIT;
                     end else begin
                        load_err_q <= 1'b1;
                     end
                  end
               end else if ((wr_proc || (wr_ctrl && reg_wdata[`PCLT_CTRL_ENABLE] &&
                  !table_enable_q)) && table_source_select_q == `PCLT_SRC_PROC) begin
                  proc_regen <= 1'b1;
                  ld_state_q <= LD_WAIT;
               end
            end
            LD_WAIT: begin
               if (fill_valid && fill_last) begin
                  ld_state_q <= LD_IDLE;
               end
            end
            default: begin
               ld_state_q <= LD_IDLE;
            end
         endcase
      end
   end

   // read port: table word taken at strobe, data valid next cycle
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_pend_q <= 1'b0;
         rd_sel_q <= 4'h0;
         rd_word_q <= {PW{1'b0}};
      end else if (clk_en) begin
         rd_pend_q <= reg_rd;
         rd_sel_q <= reg_addr;
         if (reg_rd) begin
            rd_word_q <= (reg_addr == `PCLT_REG_RED) ? tab_r[table_entry_index_q] :
               (reg_addr == `PCLT_REG_GREEN) ? tab_g[table_entry_index_q] :
               tab_b[table_entry_index_q];
         end
      end
   end

   always @* begin
      reg_rdata = 32'h00000000;
      if (rd_pend_q) begin
         case (rd_sel_q)
            `PCLT_REG_CTRL: begin
               reg_rdata[`PCLT_CTRL_ENABLE] = table_enable_q;
               reg_rdata[`PCLT_CTRL_SOURCE] = table_source_select_q;
            end
            `PCLT_REG_INFMT: reg_rdata[1:0] = infmt_q;
            `PCLT_REG_OUTFMT: reg_rdata[1:0] = outfmt_q;
            `PCLT_REG_INDEX: reg_rdata[IW-1:0] = table_entry_index_q;
            `PCLT_REG_RED, `PCLT_REG_GREEN, `PCLT_REG_BLUE: begin
               reg_rdata[PW-1:0] = rd_word_q;
            end
            `PCLT_REG_STATUS: begin
               reg_rdata[`PCLT_STAT_BUSY] = busy;
               reg_rdata[`PCLT_STAT_ERROR] = load_err_q;
               reg_rdata[`PCLT_STAT_PATH] = conv_path;
            end
            default: reg_rdata = 32'h00000000;
         endcase
      end
   end
endmodule // pclt_core
`default_nettype wire

/* pclt_core_properties.sv */
// pclt_core_properties.sv: port-level checks for pclt_core
// assumes clk_en is held high by the bench
`timescale 1ns/1ps
`default_nettype none
module pclt_core_properties (
   // clock
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // fill requests
   input wire logic proc_regen,
   input wire logic file_load,
   // pixel stream
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [15:0] out_red,
   input wire logic out_sof
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_take;
      in_valid && in_ready && !out_valid && out_ready;
   endsequence
   sequence s_flow;
      out_ready [*2];
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   regen_pulse_a: assert property (proc_regen |=> !proc_regen)
      else $error("regen request longer than one cycle");
   load_pulse_a: assert property (file_load |=> !file_load)
      else $error("load request longer than one cycle");
   regen_cause_a: assert property (proc_regen |-> $past(reg_wr) &&
      ($past(reg_addr) == 4'h9 || $past(reg_addr) == 4'h0))
      else $error("regen without a parameter or control write");
   load_cause_a: assert property (file_load |-> $past(reg_wr) &&
      $past(reg_addr) == 4'h8 && $past(reg_wdata[1:0]) == 2'h3)
      else $error("load without a valid start write");
   out_hold_a: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_red) && $stable(out_sof))
      else $error("output word changed while stalled");
   empty_ready_a: assert property (!out_valid |-> in_ready)
      else $error("input refused with empty buffer");
   fixed_latency_a: assert property (s_take ##1 s_flow |=> out_valid)
      else $error("pixel late at the output");
endmodule // pclt_core_properties
bind pclt_core pclt_core_properties i_pclt_core_properties (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .proc_regen(proc_regen),
   .file_load(file_load),
   .in_valid(in_valid),
   .in_ready(in_ready),
   .out_valid(out_valid),
   .out_ready(out_ready),
   .out_red(out_red),
   .out_sof(out_sof)
);
`default_nettype wire

/* pclt_far_model.sv */
// pclt_far_model.sv: table fill source and stalling host sink
// assumes one request pulse per fill; fills N entries from index 0
`timescale 1ns/1ps
`default_nettype none
module pclt_far_model #(
   parameter N = 4
) (
   // clock
   input wire logic sys_clk,
   input wire logic sys_rst,
   // bench control
   input wire logic stall,
   // requests from the stage
   input wire logic proc_regen,
   input wire logic file_load,
   // pixel sink
   output logic out_ready,
   // table fill
   output logic fill_valid,
   output logic [13:0] fill_index,
   output logic [15:0] fill_red,
   output logic [15:0] fill_green,
   output logic [15:0] fill_blue,
   output logic signed [17:0] fill_raw_red,
   output logic signed [17:0] fill_raw_green,
   output logic signed [17:0] fill_raw_blue,
   output logic fill_use_raw,
   output logic fill_last
);
   logic [4:0] cnt_q = 5'h0;
   logic [1:0] tick_q = 2'h0;
   logic [13:0] idx;
   always @(posedge sys_clk) begin
      tick_q <= tick_q + 2'h1;
      if (sys_rst) begin
         cnt_q <= 5'h0;
         fill_use_raw <= 1'b0;
      end else if (proc_regen || file_load) begin
         cnt_q <= 5'h1;
         fill_use_raw <= proc_regen;
      end else if (cnt_q == 5'(N + 4)) begin
         cnt_q <= 5'h0;
      end else if (cnt_q != 5'h0) begin
         cnt_q <= cnt_q + 5'h1;
      end
   end
   // idle lines toggle so a stale value is never mistaken for data
   always_comb begin
      idx = 14'(cnt_q) - 14'h5;
      fill_valid = cnt_q >= 5'h5;
      fill_last = fill_valid && idx == 14'(N - 1);
      fill_index = fill_valid ? idx : {7{tick_q[0], ~tick_q[0]}};
      fill_red = fill_valid ? 16'h1000 + 16'(idx) : {8{tick_q}};
      fill_green = fill_valid ? 16'h2000 + 16'(idx) : {8{~tick_q}};
      fill_blue = fill_valid ? 16'h3000 + 16'(idx) : {8{tick_q}};
      fill_raw_red = fill_valid ? -18'sd5 : {9{tick_q}};
      fill_raw_green = fill_valid ? 18'sd70000 : {9{~tick_q}};
      fill_raw_blue = fill_valid ? 18'(100 + idx) : {9{tick_q}};
   end
   // slow host, while stall is high, is ready one cycle in four
   assign out_ready = !stall || tick_q == 2'h3;
endmodule // pclt_far_model
`default_nettype wire

/* pclt_core_tb_top.sv */
// pclt_core_tb_top.sv: self-checking bench for pclt_core
// assumes the far model answers fills and stalls the output on request
`timescale 1ns/1ps
`default_nettype none
module pclt_core_tb_top;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
   logic in_valid = 1'b0, in_sof = 1'b0, in_eol = 1'b0, rd_seen = 1'b0, sup;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [15:0] in_red = 16'h0, in_green = 16'h0, in_blue = 16'h0, r, g, b, y;
   logic [15:0] tr[0:3], tg[0:3], tb[0:3];
   logic [1:0] fi, fo, m;
   logic [31:0] rq[$];
   logic [49:0] pq[$];
   integer seed = 26020, miscompares = 0, checked = 0, cycles = 0, loads = 0, i;
   wire [31:0] reg_rdata;
   wire [15:0] out_red, out_green, out_blue, fill_red, fill_green, fill_blue;
   wire signed [17:0] fill_raw_red, fill_raw_green, fill_raw_blue;
   wire [13:0] fill_index;
   wire fill_valid, fill_use_raw, fill_last, proc_regen, file_load, in_ready, out_valid;
   wire out_ready, out_sof, out_eol;
   pclt_core i_pclt_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fill_valid(fill_valid), .fill_index(fill_index),
      .fill_red(fill_red), .fill_green(fill_green), .fill_blue(fill_blue),
      .fill_raw_red(fill_raw_red), .fill_raw_green(fill_raw_green),
      .fill_raw_blue(fill_raw_blue), .fill_use_raw(fill_use_raw), .fill_last(fill_last),
      .proc_regen(proc_regen), .file_load(file_load), .in_valid(in_valid),
      .in_ready(in_ready), .in_red(in_red), .in_green(in_green), .in_blue(in_blue),
      .in_sof(in_sof), .in_eol(in_eol), .out_valid(out_valid), .out_ready(out_ready),
      .out_red(out_red), .out_green(out_green), .out_blue(out_blue),
      .out_sof(out_sof), .out_eol(out_eol));
   pclt_far_model i_pclt_far_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
      .proc_regen(proc_regen), .file_load(file_load), .out_ready(out_ready),
      .fill_valid(fill_valid), .fill_index(fill_index), .fill_red(fill_red),
      .fill_green(fill_green), .fill_blue(fill_blue), .fill_raw_red(fill_raw_red),
      .fill_raw_green(fill_raw_green), .fill_raw_blue(fill_raw_blue),
      .fill_use_raw(fill_use_raw), .fill_last(fill_last));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task check(input string name, input logic [49:0] seen, input logic [49:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task summarize;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // results are matched oldest first against the drivers' notes
   always @(posedge sys_clk) begin
      rd_seen <= reg_rd && !sys_rst;
      cycles <= cycles + 1;
      loads <= loads + file_load;
      if (rd_seen) check("reg_rdata", reg_rdata, rq.pop_front());
      if (out_valid && out_ready) check("pixel", {out_red, out_green, out_blue, out_sof,
         out_eol}, pq.size() ? pq.pop_front() : 50'bx);
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end
   task wr(input logic [3:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge sys_clk);
   endtask
   task idle(input integer n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      in_valid <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   task px(input logic [15:0] er, input logic [15:0] eg, input logic [15:0] eb);
      integer k;
      m = 2'($random(seed));
      pq.push_back({er, eg, eb, m});
      // a strobe left high by the last bus task would repeat its access
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      in_valid <= 1'b1;
      {in_red, in_green, in_blue, in_sof, in_eol} <= {r, g, b, m};
      @(negedge sys_clk);
      for (k = 0; k < 64 && in_ready !== 1'b1; k++) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask
   task drain;
      integer k;
      idle(1);
      for (k = 0; k < 64 && pq.size() != 0; k++) @(posedge sys_clk);
   endtask
   task wait_fill;
      integer k;
      idle(2);
      for (k = 0; k < 40 && !(fill_valid && fill_last); k++) @(posedge sys_clk);
      @(posedge sys_clk);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(4'h0, 32'h0);
      rd(4'h2, 32'h0);
      rd(4'hF, 32'h0);
      rd(4'h7, 32'h4);
      idle(2);
      $display("test defaults done");
      for (i = 0; i < 16; i++) begin
         {fi, fo} = 4'(i);
         sup = (fo <= 2'h1 && fi <= 2'h2) || fi == fo && fi >= 2'h2;
         wr(4'h1, {30'h0, fi});
         wr(4'h2, {30'h0, fo});
         rd(4'h7, {29'h0, sup, 2'h0});
         {r, g, b} = 48'({$random(seed), $random(seed)});
         // mono output is the weighted sum (r + 2g + b) / 4
         y = 16'((18'(r) + 18'(g) * 18'h2 + 18'(b)) >> 2);
         if (!sup || fi == fo || fi != 2'h0 && fo != 2'h0) px(r, g, b);
         else if (fo == 2'h1) px(r, r, r);
         else px(y, y, y);
         drain();
      end
      $display("test conversion done");
      wr(4'h3, 32'h1);
      wr(4'h4, 32'h1234);
      wr(4'h9, 32'h0);
      wait_fill();
      for (i = 0; i < 4; i++) begin
         {tr[i], tg[i], tb[i]} = {16'h0, 16'hFFFF, 16'(100 + i)};
         wr(4'h3, i);
         rd(4'h4, 32'h0);
         rd(4'h5, 32'hFFFF);
         rd(4'h6, 100 + i);
      end
      rd(4'h7, 32'h4);
      wr(4'h3, 32'h2);
      wr(4'h4, 32'hABCD);
      rd(4'h4, 32'hABCD);
      rd(4'h5, 32'hFFFF);
      tr[2] = 16'hABCD;
      $display("test table fill done");
      wr(4'h0, 32'h2);
      wr(4'h0, 32'h3);
      idle(2);
      for (i = 0; i < 32; i++) begin
         stall <= i[2];
         if (i == 16) begin
            drain();
            wr(4'h0, 32'h2);
            idle(1);
         end
         {r, g, b} = {12'h0, 4'($random(seed)), 12'h0, 4'($random(seed)), 12'h0,
            4'($random(seed))};
         if (i < 16) px(tr[r[3:2]], tg[g[3:2]], tb[b[3:2]]);
         else px(r, g, b);
      end
      drain();
      stall <= 1'b0;
      $display("test remap done");
      wr(4'h8, 32'h1);
      rd(4'h7, 32'h6);
      wr(4'h8, 32'h3);
      wait_fill();
      for (i = 0; i < 4; i++) begin
         wr(4'h3, i);
         rd(4'h4, 32'h1000 + i);
         rd(4'h6, 32'h3000 + i);
      end
      wr(4'h0, 32'h0);
      wr(4'h8, 32'h3);
      idle(4);
      check("loads", loads, 1);
      $display("test file load done");
      check("pending", rq.size() + pq.size(), 0);
      summarize();
   end
endmodule // pclt_core_tb_top
`default_nettype wire
